// >>> rtl/svm_pkg.sv
// Behaviour
// - four-bit threshold select, codes 0x3 to 0xf
// - detector_on starts and stops detection
// - below_threshold reads one when supply low
// - drop sets event flag while detection on
// - event flag sticky until software clears
// - request raised when flag and enable set
// - enable resets to zero, blocks request
// - writing one to flag clears it
// - no interrupt for already-low supply
// - software clears flag before enabling
// - software waits 500 us before polling
// - router input configured level triggered
// - handler clears flag in this block
// - drop interrupt uses vector nine, 0x8024
// - registers eight bits, reserved written zero
package svm_pkg;
  // ----------------------------------------
  // register map (byte index; ctrl/cstat apb address is the low 16 bits of four times it)
  // ----------------------------------------
  localparam logic [15:0] SVM_IDX_ENABLE = 16'h5100;
  localparam logic [15:0] SVM_IDX_LEVEL = 16'h5101;
  localparam logic [15:0] SVM_IDX_RESULT = 16'h5102;
  localparam logic [15:0] SVM_IDX_MASK = 16'h5103;
  localparam logic [15:0] SVM_IDX_STATUS = 16'h5104;
  localparam logic [15:0] SVM_IDX_CTRL = 16'h5110;
  localparam logic [15:0] SVM_IDX_CSTAT = 16'h5111;
  // ----------------------------------------
  // fields and reset values
  // ----------------------------------------
  localparam int SVM_BIT_D0 = 0;
  localparam int SVM_LEVEL_W = 4;
  localparam logic [3:0] SVM_LEVEL_MIN = 4'h3;
  localparam logic [3:0] SVM_LEVEL_RST = 4'h0;
  localparam logic [7:0] SVM_REG_RST = 8'h00;
  localparam int SVM_VECTOR_NUM = 9;
  localparam logic [15:0] SVM_VECTOR_ADDR = 16'h8024;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int SVM_CLK_HZ = 40000000;
  localparam int SVM_SETTLE_US = 500;
  localparam int SVM_SETTLE_CYC = SVM_SETTLE_US * (SVM_CLK_HZ / 1000000);
  // ----------------------------------------
  // controller commands (ctrl register)
  // ----------------------------------------
  localparam int SVM_CMD_GO = 0;
  localparam int SVM_CMD_WR = 1;
  localparam int SVM_CMD_IDX_LSB = 8;
  localparam int SVM_CMD_DAT_LSB = 24;
endpackage

// >>> rtl/svm_link_if.sv
// register port of the monitor plus its interrupt request
interface svm_link_if;
  logic sel;
  logic wr;
  logic [15:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic irq;
  modport monitor (input sel, input wr, input idx, input wdata, output rdata, output irq);
  modport router (output sel, output wr, output idx, output wdata, input rdata, input irq);
endinterface

// >>> rtl/svm_monitor.sv
// The APB register port is this design's own decision.
module svm_monitor
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register port and interrupt
  svm_link_if.monitor link,
  // analog comparator
  input wire logic cmp_below_async,
  output logic cmp_on,
  output logic [3:0] cmp_level
);
  logic on_reg;
  logic [3:0] level_reg;
  logic ie_reg;
  logic flag_reg;
  logic [2:0] sync_reg;
  logic below_reg;
  logic below_prev_reg;
  logic crossing;
  logic wr_status;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      on_reg <= 1'b0;
      level_reg <= svm_pkg::SVM_LEVEL_RST;
      ie_reg <= 1'b0;
    end
    else if (link.sel && link.wr)
    begin
      if (link.idx == svm_pkg::SVM_IDX_ENABLE)
        on_reg <= link.wdata[svm_pkg::SVM_BIT_D0];
      if (link.idx == svm_pkg::SVM_IDX_LEVEL)
        level_reg <= link.wdata[svm_pkg::SVM_LEVEL_W-1:0];
      if (link.idx == svm_pkg::SVM_IDX_MASK)
        ie_reg <= link.wdata[svm_pkg::SVM_BIT_D0];
    end
  end

  assign cmp_on = on_reg;
  assign cmp_level = level_reg;

  // ----------------------------------------
  // comparator input
  // ----------------------------------------
  // three-stage synchroniser
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_reg <= 3'h0;
    else
      sync_reg <= {sync_reg[1:0], cmp_below_async};
  end

  // result follows agreed samples, zero while off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      below_reg <= 1'b0;
      below_prev_reg <= 1'b0;
    end
    else
    begin
      if (!on_reg)
        below_reg <= 1'b0;
      else if (sync_reg[1] == sync_reg[2])
        below_reg <= sync_reg[2];
      below_prev_reg <= below_reg;
    end
  end

  // only a fresh downward crossing counts
  assign crossing = on_reg && below_reg && !below_prev_reg;
  assign wr_status = link.sel && link.wr && link.idx == svm_pkg::SVM_IDX_STATUS
    && link.wdata[svm_pkg::SVM_BIT_D0];

  // ----------------------------------------
  // event flag
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_reg <= 1'b0;
    else if (crossing)
      flag_reg <= 1'b1;
    else if (wr_status)
      flag_reg <= 1'b0;
  end

  // level request, to the cpu irq pin through the router's pending flag and mask
  assign link.irq = flag_reg && ie_reg;

  // ----------------------------------------
  // read mux, eight bits, reserved read zero
  // ----------------------------------------
  always_comb
  begin
    link.rdata = svm_pkg::SVM_REG_RST;
    unique case (link.idx)
      svm_pkg::SVM_IDX_ENABLE: link.rdata = {7'h00, on_reg};
      svm_pkg::SVM_IDX_LEVEL: link.rdata = {4'h0, level_reg};
      svm_pkg::SVM_IDX_RESULT: link.rdata = {7'h00, below_reg};
      svm_pkg::SVM_IDX_MASK: link.rdata = {7'h00, ie_reg};
      svm_pkg::SVM_IDX_STATUS: link.rdata = {7'h00, flag_reg};
      default: link.rdata = svm_pkg::SVM_REG_RST;
    endcase
  end
endmodule

// >>> rtl/svm_router.sv
module svm_router
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt to cpu
  output logic irq,
  // monitor side
  svm_link_if.router link
);
  logic [31:0] ctrl_reg;
  logic [7:0] rd_reg;
  logic busy_reg;
  logic pending_reg;
  logic mask_reg;
  logic access;
  logic wr_ctrl;
  logic wr_stat;

  assign access = psel && penable;
  assign pready = 1'b1;
  assign pslverr = access && paddr != {svm_pkg::SVM_IDX_CTRL[13:0], 2'b00}
    && paddr != {svm_pkg::SVM_IDX_CSTAT[13:0], 2'b00};
  assign wr_ctrl = access && pwrite && paddr == {svm_pkg::SVM_IDX_CTRL[13:0], 2'b00};
  assign wr_stat = access && pwrite && paddr == {svm_pkg::SVM_IDX_CSTAT[13:0], 2'b00};

  // ----------------------------------------
  // command register and one-cycle access
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= 32'h0;
      busy_reg <= 1'b0;
      rd_reg <= 8'h00;
    end
    else
    begin
      busy_reg <= 1'b0;
      if (wr_ctrl)
      begin
        ctrl_reg <= pwdata;
        busy_reg <= pwdata[svm_pkg::SVM_CMD_GO];
      end
      if (busy_reg)
        rd_reg <= link.rdata;
    end
  end

  // reserved data bits passed through from ctrl as software wrote them
  assign link.sel = busy_reg;
  assign link.wr = ctrl_reg[svm_pkg::SVM_CMD_WR];
  assign link.idx = ctrl_reg[svm_pkg::SVM_CMD_IDX_LSB +: 16];
  assign link.wdata = ctrl_reg[svm_pkg::SVM_CMD_DAT_LSB +: 8];

  // ----------------------------------------
  // pending flag and mask
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pending_reg <= 1'b0;
      mask_reg <= 1'b0;
    end
    else
    begin
      // level input: pending sets while the request is high; writing one to bit 0 clears it
      if (link.irq)
        pending_reg <= 1'b1;
      else if (wr_stat && pwdata[0])
        pending_reg <= 1'b0;
      if (wr_stat)
        mask_reg <= pwdata[8];
    end
  end

  assign irq = pending_reg && mask_reg;

  always_comb
  begin
    prdata = 32'h0;
    if (paddr == {svm_pkg::SVM_IDX_CTRL[13:0], 2'b00})
      prdata = {rd_reg, ctrl_reg[23:0]};
    else if (paddr == {svm_pkg::SVM_IDX_CSTAT[13:0], 2'b00})
      prdata = {23'h0, mask_reg, 7'h0, pending_reg};
  end
endmodule

// >>> bench/svm_chk_monitor.sv
module svm_chk_monitor
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic sel,
  input wire logic wr,
  input wire logic [15:0] idx,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic irq,
  // comparator
  input wire logic cmp_below_async,
  input wire logic cmp_on,
  input wire logic [3:0] cmp_level
);
  timeunit 1ns;
  timeprecision 1ps;
  logic mask_q;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mask_q <= 1'b0;
    else if (sel && wr && idx == 16'h5103)
      mask_q <= wdata[0];
  property p_on;
    sel && wr && idx == 16'h5100 |=> cmp_on == $past(wdata[0]);
  endproperty
  a_on: assert property (p_on) else $error("detector power not following write");
  property p_level;
    sel && wr && idx == 16'h5101 |=> cmp_level == $past(wdata[3:0]);
  endproperty
  a_level: assert property (p_level) else $error("threshold code not following write");
  property p_res_off;
    (!cmp_on)[*3] ##0 idx == 16'h5102 |-> rdata == 8'h00;
  endproperty
  a_res_off: assert property (p_res_off) else $error("result not zero while off");
  property p_res_hi;
    (cmp_on && cmp_below_async)[*8] ##0 idx == 16'h5102 |-> rdata == 8'h01;
  endproperty
  a_res_hi: assert property (p_res_hi) else $error("result not one for low supply");
  property p_rsv;
    sel && idx != 16'h5101 |-> rdata[7:1] == 7'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  property p_mask0;
    idx == 16'h5103 && rdata == 8'h00 && $past(idx == 16'h5103 && rdata == 8'h00) |-> !irq;
  endproperty
  a_mask0: assert property (p_mask0) else $error("request while enable is zero");
  property p_sticky;
    idx == 16'h5104 && $past(idx == 16'h5104 && rdata[0] && !(sel && wr && wdata[0])) |-> rdata[0];
  endproperty
  a_sticky: assert property (p_sticky) else $error("event flag dropped by itself");
  property p_clr;
    cmp_below_async[*6] ##0 (sel && wr && idx == 16'h5104 && wdata[0]) |-> ##2 !irq;
  endproperty
  a_clr: assert property (p_clr) else $error("request stays after flag clear");
  property p_set;
    (cmp_on && mask_q && !cmp_below_async) ##1 (cmp_on && mask_q && cmp_below_async)[*8] |-> irq;
  endproperty
  a_set: assert property (p_set) else $error("no request after downward crossing");
  c_irq: cover property (irq);
  c_clr: cover property (sel && wr && idx == 16'h5104);
  c_low: cover property (cmp_on && cmp_below_async);
endmodule

// >>> bench/supply_voltage_drop_monitor_tb.sv
module supply_voltage_drop_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic below = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, on;
  logic [3:0] lv;
  logic [3:0] lvl;
  logic [7:0] exp_q[$];
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'h05d533fd;
  svm_link_if link();
  always #12.5 pclk = ~pclk;
  svm_monitor i_svm_monitor (.pclk(pclk), .presetn(presetn), .link(link), .cmp_below_async(below), .cmp_on(on),
    .cmp_level(lvl));
  svm_router i_svm_router (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
  svm_chk_monitor i_chk (.pclk(pclk), .presetn(presetn), .sel(link.sel), .wr(link.wr), .idx(link.idx),
    .wdata(link.wdata), .rdata(link.rdata), .irq(link.irq), .cmp_below_async(below), .cmp_on(on), .cmp_level(lvl));
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] read %h exp %h got %h", paddr, e, g);
    end
  endtask
  task give_verdict;
    if (fail_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic lk(input logic [15:0] i, input logic w, input logic [7:0] d);
    apb(16'h4440, 1'b1, {d, i, 6'h00, w, 1'b1});
  endtask
  task automatic rd(input logic [15:0] i, input logic [7:0] e);
    lk(i, 1'b0, 8'h00);
    exp_q.push_back(e);
    apb(16'h4440, 1'b0, 32'h0);
  endtask
  // ----------------------------------------
  // result watcher and stimulus
  // ----------------------------------------
  // watcher adds the cpu request pin as bit one of the router status byte
  function automatic logic [7:0] got_byte();
    if (paddr == 16'h4440)
      return prdata[31:24];
    else if (paddr == 16'h4444)
      return {6'h00, irq, prdata[0]};
    return {7'h00, pslverr};
  endfunction
  always @(posedge pclk)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk(exp_q.pop_front(), got_byte());
  initial
  begin
    // settle wait alone is 20000 cycles
    repeat (40000) @(posedge pclk);
    fail_count++;
    give_verdict;
  end
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(16'h5100, 8'h00);
    rd(16'h5101, 8'h00);
    rd(16'h5103, 8'h00);
    rd(16'h5104, 8'h00);
    // all codes, then one random code
    for (int i = 3; i < 17; i++)
    begin
      lv = (i == 16) ? 4'h3 + 4'($unsigned($random(seed)) % 13) : 4'(i);
      lk(16'h5101, 1'b1, {4'h0, lv});
      rd(16'h5101, {4'h0, lv});
    end
    below <= 1'b1;
    rd(16'h5102, 8'h00);
    below <= 1'b0;
    lk(16'h5100, 1'b1, 8'h01);
    repeat (svm_pkg::SVM_SETTLE_CYC) @(posedge pclk);
    rd(16'h5102, 8'h00);
    below <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(16'h5102, 8'h01);
    rd(16'h5104, 8'h01);
    below <= 1'b0;
    rd(16'h5104, 8'h01);
    lk(16'h5104, 1'b1, 8'h01);
    rd(16'h5104, 8'h00);
    below <= 1'b1;
    repeat (8) @(posedge pclk);
    // clear while low, then enable: no new crossing
    lk(16'h5104, 1'b1, 8'h01);
    lk(16'h5103, 1'b1, 8'h01);
    rd(16'h5104, 8'h00);
    apb(16'h4444, 1'b1, 32'h0000_0101);
    below <= 1'b0;
    repeat (8) @(posedge pclk);
    below <= 1'b1;
    repeat (8) @(posedge pclk);
    exp_q.push_back(8'h03);
    apb(16'h4444, 1'b0, 32'h0);
    lk(16'h5104, 1'b1, 8'h01);
    apb(16'h4444, 1'b1, 32'h0000_0101);
    exp_q.push_back(8'h00);
    apb(16'h4444, 1'b0, 32'h0);
    lk(16'h5100, 1'b1, 8'h00);
    rd(16'h5102, 8'h00);
    exp_q.push_back(8'h01);
    apb(16'h4448, 1'b0, 32'h0);
    // the watcher took the last answer at the read's final edge, one edge before this one
    @(posedge pclk);
    if (exp_q.size() != 0)
      fail_count++;
    give_verdict;
  end
endmodule
